// ---- e1nb_defs.svh ----
// Purpose: constants for the national-bit interrupt and signalling control block
// Assumes: byte-wide host port, page select presented beside the address
// Notes:   reset values of both control words are zero
`ifndef E1NB_DEFS_SVH
`define E1NB_DEFS_SVH

`define E1NB_PAGE            8'h01
`define E1NB_ADDR_MASK       5'h19
`define E1NB_ADDR_CTRL       5'h1A
`define E1NB_MASK_RST        8'h00
`define E1NB_CTRL_RST        8'h00
`define E1NB_MASK_USED       8'h7F
`define E1NB_VECTOR          8'h02
`define E1NB_VECTOR_IDLE     8'h00
`define E1NB_PRBS_MAX        8'hFF
`define E1NB_PRBS_ZERO       8'h00
`define E1NB_SAME_RUN        4'h8
`define E1NB_SIG_PAD         4'h0
`define E1NB_TX_CHAN_TICKS   16
`define E1NB_RX_CHAN_TICKS   8

`endif

// ---- e1nb_pkg.sv ----
// Purpose: shared types of the national-bit interrupt and signalling control block
// Assumes: field order of each struct matches the register bit order, MSB first
// Notes:   none
`default_nettype none
package e1nb_pkg;

	typedef struct packed {
		logic unused;
		logic prbs_overflow_irq_en;
		logic prbs_error_irq_en;
		logic national_nibble_change_irq_en;
		logic national_bit_change_irq_en;
		logic eight_same_nibble_irq_en;
		logic nibble6_change_irq_en;
		logic bit5_change_irq_en;
	} e1nb_mask_type;

	typedef struct packed {
		logic serial_out_enable;
		logic irq_suspend;
		logic irq_ack_toggle;
		logic tx_common_chan_sig;
		logic reg_sourced_signalling;
		logic counters_clear;
		logic sig_nibble_upper;
		logic ccs_64k_mode;
	} e1nb_ctrl_type;

	typedef struct packed {
		logic nib_chg;
		logic bit_chg;
		logic eight_same;
		logic nib6_chg;
		logic bit5_chg;
	} e1nb_sa_evt_type;

endpackage
`default_nettype wire

// ---- e1nb_sa_watch.sv ----
// Purpose: change and repeat detection on received national-use bits
// Assumes: strobes are one-cycle pulses; nibble n sits at bits 4n+3..4n, n=0 is Sa5
// Notes:   first sample after reset only primes the history
`default_nettype none
`include "e1nb_defs.svh"
module e1nb_sa_watch (
	input  wire logic                  clk,          // System clock
	input  wire logic                  rst,          // Sync reset
	input  wire logic                  bit_valid,    // New Sa bits
	input  wire logic [3:0]            sa_bits,      // Sa8..Sa5
	input  wire logic                  nib_valid,    // New Sa nibbles
	input  wire logic [15:0]           sa_nibbles,   // Sa8..Sa5 nibbles
	output e1nb_pkg::e1nb_sa_evt_type  evt           // Event pulses
);
	logic [3:0]  bits_q;
	logic [15:0] nibs_q;
	logic        bit_primed_q;
	logic        nib_primed_q;
	logic [3:0]  run_q;
	logic [3:0]  nib_diff;
	logic        same6;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_nib
			assign nib_diff[g] = nibs_q[4*g +: 4] != sa_nibbles[4*g +: 4];
		end
	endgenerate
	assign same6 = !nib_diff[1];

	always_ff @(posedge clk) begin
		if (rst) begin
			bits_q       <= 4'h0;
			nibs_q       <= 16'h0000;
			bit_primed_q <= 1'b0;
			nib_primed_q <= 1'b0;
			run_q        <= 4'h0;
		end else begin
			if (bit_valid) begin
				bits_q       <= sa_bits;
				bit_primed_q <= 1'b1;
			end
			if (nib_valid) begin
				nibs_q       <= sa_nibbles;
				nib_primed_q <= 1'b1;
				// Saturate so the run fires once only
				if (!nib_primed_q || !same6)
					run_q <= 4'h1;
				else if (run_q != `E1NB_SAME_RUN)
					run_q <= run_q + 4'h1;
			end
		end
	end

	assign evt.bit_chg    = bit_valid && bit_primed_q && (bits_q != sa_bits);
	assign evt.bit5_chg   = bit_valid && bit_primed_q && (bits_q[0] != sa_bits[0]);
	assign evt.nib_chg    = nib_valid && nib_primed_q && (|nib_diff);
	assign evt.nib6_chg   = nib_valid && nib_primed_q && nib_diff[1];
	assign evt.eight_same = nib_valid && nib_primed_q && same6
		&& (run_q == `E1NB_SAME_RUN - 4'h1);
endmodule
`default_nettype wire

// ---- e1nb_ccs_clk.sv ----
// Purpose: 64 kHz common channel clock aligned to channel boundaries
// Assumes: tick_en pulses once per bit-clock period, frame marks tick 0 of channel 0
// Notes:   clock is high for channels 2,3 of every group of four
`default_nettype none
module e1nb_ccs_clk #(
	parameter int CHAN_TICKS = 16                 // Ticks per channel
) (
	input  wire logic clk,                        // System clock
	input  wire logic rst,                        // Sync reset
	input  wire logic tick_en,                    // Bit-rate enable
	input  wire logic frame,                      // Frame start
	output logic      ccs_clk,                    // 64 kHz level
	output logic      rise                        // Rising edge pulse
);
	localparam int HW = $clog2(CHAN_TICKS) + 2;
	logic [HW-1:0] cnt_q;
	logic [HW-1:0] cnt_d;

	assign cnt_d   = frame ? '0 : cnt_q + 1'b1;
	assign ccs_clk = cnt_q[HW-1];
	assign rise    = tick_en && (cnt_d == {1'b1, {(HW-1){1'b0}}});

	always_ff @(posedge clk) begin
		if (rst)
			cnt_q <= '0;
		else if (tick_en)
			cnt_q <= cnt_d;
	end

	// Edge lands on the start of channel 2 of each group
	ccs_edge_a: assert property (@(posedge clk) disable iff (rst)
		$rose(ccs_clk) |-> $past(cnt_q) == {1'b0, {(HW-1){1'b1}}})
		else $error("ccs clock rose off a channel boundary");
endmodule
`default_nettype wire

// ---- e1nb_ctrl.sv ----
// Purpose: national-bit interrupt mask and interrupt/signalling control words
// Assumes: host port inputs are synchronous; one write per strobe assertion
// Notes:   irq and serial outputs are split into value and drive enable
`default_nettype none
`include "e1nb_defs.svh"
module e1nb_ctrl (
	input  wire logic        clk,                     // 125 MHz clock
	input  wire logic        rst,                     // Sync reset, high
	input  wire logic        cs_n,                    // Chip select
	input  wire logic        rd_n,                    // Read strobe
	input  wire logic        wr_n,                    // Write strobe
	input  wire logic [7:0]  page,                    // Register page
	input  wire logic [4:0]  addr,                    // Register address
	input  wire logic [7:0]  wdata,                   // Write data
	output logic      [7:0]  rdata,                   // Read data
	output logic             rdata_oe,                // Read data drive
	input  wire logic [7:0]  prbs_err_cnt,            // PRBS error counter
	input  wire logic        prbs_err_pulse,          // PRBS bit error
	input  wire logic        sa_bit_valid,            // New Sa bits
	input  wire logic [3:0]  sa_bits,                 // Sa8..Sa5
	input  wire logic        sa_nib_valid,            // New Sa nibbles
	input  wire logic [15:0] sa_nibbles,              // Sa8..Sa5 nibbles
	input  wire logic        bp_clk_en,               // Backplane 4 MHz tick
	input  wire logic        bp_frame,                // Backplane frame start
	input  wire logic        rx_line_clk_en,          // Recovered clock tick
	input  wire logic        rx_frame,                // Receive frame start
	input  wire logic        tx_data_bit,             // Data stream bit
	input  wire logic        tx_sig_bit,              // CAS stream bit
	input  wire logic        serial_sig_in,           // Signalling input
	input  wire logic [7:0]  sig_slot_byte,           // Input slot byte
	input  wire logic        sig_slot_valid,          // Slot byte strobe
	input  wire logic [3:0]  reg_cas_nibble,          // Register CAS bits
	input  wire logic        data_out_alarm_tristate, // Data alarm gate
	input  wire logic        sig_out_alarm_tristate,  // Sig alarm gate
	input  wire logic        rx_los,                  // Loss of signal
	input  wire logic        rx_lofs,                 // Loss of frame sync
	input  wire logic        rx_locrc,                // Loss of CRC-4 sync
	input  wire logic        rx_ais,                  // Received AIS
	input  wire logic        rx_lomf,                 // Loss of multiframe
	input  wire logic        rx_ais16,                // Received AIS16
	output logic             serial_data_out,         // Data output value
	output logic             serial_data_oe,          // Data output drive
	output logic             serial_sig_out,          // Sig output value
	output logic             serial_sig_oe,           // Sig output drive
	output logic             irq_n,                   // Interrupt, low
	output logic             irq_oe,                  // Interrupt drive
	output logic      [7:0]  irq_vector,              // Pending vector
	output logic             tx_common_chan_sig,      // Tx CCS mode
	output logic             counters_clear,          // Hold counters zero
	output logic      [3:0]  tx_cas_nibble,           // Tx CAS nibble
	output logic      [3:0]  rx_cas_nibble,           // Stream CAS nibble
	output logic             ccs_tx_clk,              // Internal 64k clock
	output logic             rx_ccs_clk_out           // Rx 64k clock pin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	e1nb_pkg::e1nb_mask_type   mask_q;
	e1nb_pkg::e1nb_ctrl_type   ctrl_q;
	e1nb_pkg::e1nb_ctrl_type   ctrl_w;
	e1nb_pkg::e1nb_sa_evt_type sa_evt;

	logic       wr_prev_q;
	logic [7:0] prbs_prev_q;
	logic       pend_q;
	logic       ccs_bit_q;
	logic       tx_ccs_clk_w;
	logic       tx_ccs_rise;
	logic       rx_ccs_clk_w;
	logic [15:0] nib_seen_q;
	logic        nib_seen_ok_q;

	// Host port decode
	wire        page_hit   = page == `E1NB_PAGE;
	wire        wr_act     = !cs_n && !wr_n;
	wire        wr_stb     = wr_act && !wr_prev_q;
	wire        hit_mask   = page_hit && addr == `E1NB_ADDR_MASK;
	wire        hit_ctrl   = page_hit && addr == `E1NB_ADDR_CTRL;
	wire        wr_mask    = wr_stb && hit_mask;
	wire        wr_ctrl    = wr_stb && hit_ctrl;
	wire        rd_act     = !cs_n && !rd_n && (hit_mask || hit_ctrl);
	wire  [7:0] rd_mux     = hit_mask ? mask_q : hit_ctrl ? ctrl_q : 8'h00;
	assign ctrl_w = wdata;

	// Interrupt sources
	wire prbs_wrap  = prbs_prev_q == `E1NB_PRBS_MAX && prbs_err_cnt == `E1NB_PRBS_ZERO;
	wire src_prbs_overflow_irq_en  = mask_q.prbs_overflow_irq_en && prbs_wrap;
	wire src_prbs_error_irq_en  = mask_q.prbs_error_irq_en && prbs_err_pulse;
	wire src_nib    = mask_q.national_nibble_change_irq_en && sa_evt.nib_chg;
	wire src_bit    = mask_q.national_bit_change_irq_en && sa_evt.bit_chg;
	wire src_same   = mask_q.eight_same_nibble_irq_en && sa_evt.eight_same;
	wire src_nib6   = mask_q.nibble6_change_irq_en && sa_evt.nib6_chg;
	wire src_bit5   = mask_q.bit5_change_irq_en && sa_evt.bit5_chg;
	wire any_src    = src_prbs_overflow_irq_en || src_prbs_error_irq_en || src_nib || src_bit
		|| src_same || src_nib6 || src_bit5;
	// Suspended sources are dropped, not deferred
	wire irq_set    = any_src && !ctrl_q.irq_suspend;
	wire ack_evt    = wr_ctrl && ctrl_w.irq_ack_toggle != ctrl_q.irq_ack_toggle;
	// A source in the acknowledge cycle survives it
	wire pend_d     = irq_set ? 1'b1 : ack_evt ? 1'b0 : pend_q;

	// Serial output gating
	wire data_alarm = rx_los || rx_lofs || rx_locrc || rx_ais;
	wire sig_alarm  = rx_lomf || rx_ais16;
	wire data_oe_d  = ctrl_q.serial_out_enable
		&& !(data_out_alarm_tristate && data_alarm);
	wire sig_oe_d   = ctrl_q.serial_out_enable
		&& !(sig_out_alarm_tristate && sig_alarm);
	wire sig_out_d  = ctrl_q.ccs_64k_mode ? ccs_bit_q : tx_sig_bit;

	// Signalling nibble placement and source
	wire [3:0] slot_nib = ctrl_q.sig_nibble_upper ? sig_slot_byte[7:4]
		: sig_slot_byte[3:0];
	wire [3:0] cas_d    = ctrl_q.reg_sourced_signalling ? reg_cas_nibble
		: rx_cas_nibble;

	e1nb_sa_watch u_sa (
		.clk        (clk),
		.rst        (rst),
		.bit_valid  (sa_bit_valid),
		.sa_bits    (sa_bits),
		.nib_valid  (sa_nib_valid),
		.sa_nibbles (sa_nibbles),
		.evt        (sa_evt)
	);

	e1nb_ccs_clk #(.CHAN_TICKS(`E1NB_TX_CHAN_TICKS)) u_tx_ccs (
		.clk     (clk),
		.rst     (rst),
		.tick_en (bp_clk_en),
		.frame   (bp_frame),
		.ccs_clk (tx_ccs_clk_w),
		.rise    (tx_ccs_rise)
	);

	// Receive side counts recovered line ticks, not backplane ticks
	e1nb_ccs_clk #(.CHAN_TICKS(`E1NB_RX_CHAN_TICKS)) u_rx_ccs (
		.clk     (clk),
		.rst     (rst),
		.tick_en (rx_line_clk_en),
		.frame   (rx_frame),
		.ccs_clk (rx_ccs_clk_w),
		.rise    ()
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			mask_q    <= `E1NB_MASK_RST;
			ctrl_q    <= `E1NB_CTRL_RST;
			wr_prev_q <= 1'b0;
		end else begin
			wr_prev_q <= wr_act;
			if (wr_mask)
				mask_q <= wdata & `E1NB_MASK_USED;
			if (wr_ctrl)
				ctrl_q <= ctrl_w;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata    <= 8'h00;
			rdata_oe <= 1'b0;
		end else begin
			rdata    <= rd_act ? rd_mux : 8'h00;
			rdata_oe <= rd_act;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prbs_prev_q <= `E1NB_PRBS_ZERO;
			pend_q      <= 1'b0;
			irq_n       <= 1'b1;
			irq_oe      <= 1'b0;
			irq_vector  <= `E1NB_VECTOR_IDLE;
		end else begin
			prbs_prev_q <= prbs_err_cnt;
			pend_q      <= pend_d;
			irq_n       <= !pend_d;
			irq_oe      <= !ctrl_q.irq_suspend;
			irq_vector  <= pend_d ? `E1NB_VECTOR : `E1NB_VECTOR_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ccs_bit_q <= 1'b0;
		end else if (ctrl_q.ccs_64k_mode && tx_ccs_rise) begin
			ccs_bit_q <= serial_sig_in;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			serial_data_out    <= 1'b0;
			serial_data_oe     <= 1'b0;
			serial_sig_out     <= 1'b0;
			serial_sig_oe      <= 1'b0;
			tx_common_chan_sig <= 1'b0;
			counters_clear     <= 1'b0;
			tx_cas_nibble      <= `E1NB_SIG_PAD;
			rx_cas_nibble      <= `E1NB_SIG_PAD;
			ccs_tx_clk         <= 1'b0;
			rx_ccs_clk_out     <= 1'b0;
		end else begin
			serial_data_out    <= tx_data_bit;
			serial_data_oe     <= data_oe_d;
			serial_sig_out     <= sig_out_d;
			serial_sig_oe      <= sig_oe_d;
			tx_common_chan_sig <= ctrl_q.tx_common_chan_sig;
			counters_clear     <= ctrl_q.counters_clear;
			tx_cas_nibble      <= cas_d;
			if (sig_slot_valid)
				rx_cas_nibble <= slot_nib;
			ccs_tx_clk         <= ctrl_q.ccs_64k_mode && tx_ccs_clk_w;
			rx_ccs_clk_out     <= ctrl_q.ccs_64k_mode && rx_ccs_clk_w;
		end
	end

	// Own Sa history so the nibble check does not lean on the watcher
	always_ff @(posedge clk) begin
		if (rst) begin
			nib_seen_q    <= '0;
			nib_seen_ok_q <= 1'b0;
		end else if (sa_nib_valid) begin
			nib_seen_q    <= sa_nibbles;
			nib_seen_ok_q <= 1'b1;
		end
	end

	prbs_wrap_a: assert property (
		mask_q.prbs_overflow_irq_en && !ctrl_q.irq_suspend && prbs_wrap
		|=> pend_q && !irq_n ##0 irq_vector == `E1NB_VECTOR)
		else $error("prbs wrap did not raise irq");

	prbs_err_a: assert property (
		mask_q.prbs_error_irq_en && !ctrl_q.irq_suspend && prbs_err_pulse |=> !irq_n)
		else $error("prbs error did not raise irq");

	nib_change_a: assert property (
		mask_q.national_nibble_change_irq_en && !ctrl_q.irq_suspend && sa_nib_valid
		&& nib_seen_ok_q && sa_nibbles != nib_seen_q |=> pend_q)
		else $error("nibble change missed");

	bit_change_a: assert property (
		mask_q.national_bit_change_irq_en && !ctrl_q.irq_suspend && sa_evt.bit_chg
		|=> pend_q)
		else $error("sa bit change missed");

	eight_same_a: assert property (
		sa_evt.eight_same && mask_q.eight_same_nibble_irq_en && !ctrl_q.irq_suspend
		|=> !irq_n)
		else $error("eighth same nibble missed");

	nib6_change_a: assert property (
		sa_evt.nib6_chg && mask_q.nibble6_change_irq_en && !ctrl_q.irq_suspend
		|=> pend_q)
		else $error("sa6 change missed");

	bit5_change_a: assert property (
		sa_evt.bit5_chg && mask_q.bit5_change_irq_en && !ctrl_q.irq_suspend
		|=> !irq_n)
		else $error("sa5 change missed");

	ode_off_a: assert property (
		!ctrl_q.serial_out_enable |=> !serial_data_oe && !serial_sig_oe)
		else $error("serial outputs driven while disabled");

	alarm_float_a: assert property (
		data_out_alarm_tristate && (rx_los || rx_ais) |=> !serial_data_oe)
		else $error("data output driven during alarm");

	suspend_hiz_a: assert property (
		ctrl_q.irq_suspend ##1 ctrl_q.irq_suspend
		|-> !irq_oe && pend_q == ($past(pend_q) && !$past(ack_evt)))
		else $error("irq active while suspended");

	ack_clear_a: assert property (
		pend_q && ack_evt && !irq_set |=> !pend_q && irq_n && irq_vector == `E1NB_VECTOR_IDLE)
		else $error("ack toggle did not clear irq");

	mask_msb_a: assert property (
		rd_act && hit_mask |=> rdata == {1'b0, $past(mask_q[6:0])})
		else $error("mask readback wrong");

	cnt_clear_a: assert property (
		ctrl_q.counters_clear [*2] |-> counters_clear)
		else $error("counter clear not held");

	nib_place_a: assert property (
		sig_slot_valid && ctrl_q.sig_nibble_upper |=> rx_cas_nibble == $past(sig_slot_byte[7:4]))
		else $error("signalling nibble taken from wrong half");

	cas_source_a: assert property (
		ctrl_q.reg_sourced_signalling |=> tx_cas_nibble == $past(reg_cas_nibble))
		else $error("register signalling not used");

	cas_stream_a: assert property (
		!ctrl_q.ccs_64k_mode |=> serial_sig_out == $past(tx_sig_bit))
		else $error("signalling output not from stream");

	ccs_pass_a: assert property (
		ctrl_q.ccs_64k_mode && tx_ccs_rise ##1 ctrl_q.ccs_64k_mode
		|=> serial_sig_out == $past(serial_sig_in, 2))
		else $error("ccs bit not passed through");

	ccs_align_a: assert property (
		$rose(ccs_tx_clk) && $past(ctrl_q.ccs_64k_mode, 2) |-> $past(tx_ccs_rise, 2))
		else $error("tx ccs clock rose off its tick");

	ccs_gate_a: assert property (
		!ctrl_q.ccs_64k_mode |=> !rx_ccs_clk_out && !ccs_tx_clk)
		else $error("ccs clock out of 64k mode");

	sig_alarm_a: assert property (
		sig_out_alarm_tristate && (rx_lomf || rx_ais16) |=> !serial_sig_oe)
		else $error("signalling output driven during alarm");

	suspend_drop_a: assert property (
		ctrl_q.irq_suspend && !pend_q |=> !pend_q)
		else $error("event taken while suspended");

	set_wins_a: assert property (
		irq_set |=> pend_q && !irq_n && irq_vector == `E1NB_VECTOR)
		else $error("new event lost");
endmodule
`default_nettype wire

// ---- e1nb_stream_model.sv ----
// Purpose: backplane and recovered line timing source facing the control block
// Assumes: tick spacing shortened from the real rates to keep runs brief
// Notes:   frame marks repeat every 32 channels; signalling input toggles per backplane tick
`default_nettype none
module e1nb_stream_model #(
	parameter int BP_DIV = 2,                // Clocks per backplane tick
	parameter int RX_DIV = 4                 // Clocks per line tick
) (
	input  wire logic clk,                   // System clock
	input  wire logic rst,                   // Sync reset
	output logic      bp_clk_en,             // Backplane tick
	output logic      bp_frame,              // Backplane frame start
	output logic      rx_line_clk_en,        // Recovered tick
	output logic      rx_frame,              // Receive frame start
	output logic      serial_sig_in          // Signalling stream bit
);
	timeunit 1ns;
	timeprecision 1ps;
	int bp_n;
	int rx_n;
	int bp_t;
	int rx_t;
	// 16 ticks a channel on the backplane, 8 on the line, 32 channels a frame
	always_ff @(posedge clk) begin
		if (rst) begin
			{bp_clk_en, bp_frame, rx_line_clk_en, rx_frame, serial_sig_in} <= 5'h00;
			bp_n <= 0;
			rx_n <= 0;
			bp_t <= 0;
			rx_t <= 0;
		end else begin
			bp_n <= (bp_n == BP_DIV - 1) ? 0 : bp_n + 1;
			rx_n <= (rx_n == RX_DIV - 1) ? 0 : rx_n + 1;
			bp_clk_en <= (bp_n == 0);
			rx_line_clk_en <= (rx_n == 0);
			bp_frame <= (bp_n == 0) && (bp_t == 0);
			rx_frame <= (rx_n == 0) && (rx_t == 0);
			if (bp_n == 0) begin
				bp_t <= (bp_t == 511) ? 0 : bp_t + 1;
				serial_sig_in <= ~serial_sig_in;
			end
			if (rx_n == 0)
				rx_t <= (rx_t == 255) ? 0 : rx_t + 1;
		end
	end
endmodule
`default_nettype wire

// ---- e1nb_tb.sv ----
// Purpose: self-checking bench for the national-bit interrupt and signalling control
// Assumes: host port on page 01, stream timing from the partner model
// Notes:   every scenario is a task that judges its own results
`default_nettype none
`include "e1nb_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, cs_n, rd_n, wr_n, rdata_oe, prbs_err_pulse;
	logic [7:0]  page, wdata, rdata, prbs_err_cnt, sig_slot_byte, irq_vector, ctrl_sh;
	logic [4:0]  addr;
	logic [3:0]  sa_bits, reg_cas_nibble, tx_cas_nibble, rx_cas_nibble;
	logic [15:0] sa_nibbles;
	logic        sa_bit_valid, sa_nib_valid, bp_clk_en, bp_frame, rx_line_clk_en, rx_frame;
	logic        tx_data_bit, tx_sig_bit, serial_sig_in, sig_slot_valid;
	logic        data_out_alarm_tristate, sig_out_alarm_tristate;
	logic        rx_los, rx_lofs, rx_locrc, rx_ais, rx_lomf, rx_ais16;
	logic        serial_data_out, serial_data_oe, serial_sig_out, serial_sig_oe;
	logic        irq_n, irq_oe, tx_common_chan_sig, counters_clear, ccs_tx_clk, rx_ccs_clk_out;
	int          num_errors, num_checks, cycles, n;

	e1nb_ctrl dut (.clk, .rst, .cs_n, .rd_n, .wr_n, .page, .addr, .wdata, .rdata, .rdata_oe,
		.prbs_err_cnt, .prbs_err_pulse, .sa_bit_valid, .sa_bits, .sa_nib_valid, .sa_nibbles,
		.bp_clk_en, .bp_frame, .rx_line_clk_en, .rx_frame, .tx_data_bit, .tx_sig_bit,
		.serial_sig_in, .sig_slot_byte, .sig_slot_valid, .reg_cas_nibble,
		.data_out_alarm_tristate, .sig_out_alarm_tristate, .rx_los, .rx_lofs, .rx_locrc,
		.rx_ais, .rx_lomf, .rx_ais16, .serial_data_out, .serial_data_oe, .serial_sig_out,
		.serial_sig_oe, .irq_n, .irq_oe, .irq_vector, .tx_common_chan_sig, .counters_clear,
		.tx_cas_nibble, .rx_cas_nibble, .ccs_tx_clk, .rx_ccs_clk_out);
	e1nb_stream_model far_end (.clk, .rst, .bp_clk_en, .bp_frame, .rx_line_clk_en,
		.rx_frame, .serial_sig_in);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Generous ceiling: the full sequence needs under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic settle();
		repeat (3) @(negedge clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		if (a == `E1NB_ADDR_CTRL)
			ctrl_sh = d;
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic oe);
		@(posedge clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= a;
		@(posedge clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		@(negedge clk);
		chk(rdata, exp);
		chk({7'h00, rdata_oe}, {7'h00, oe});
	endtask

	// Keeps the acknowledge bit as it stands so no clear is sent by accident
	task automatic ctl(input logic [7:0] d);
		wr(`E1NB_ADDR_CTRL, (d & 8'hDF) | (ctrl_sh & 8'h20));
		settle();
	endtask

	task automatic ack();
		wr(`E1NB_ADDR_CTRL, ctrl_sh ^ 8'h20);
		repeat (2) @(negedge clk);
	endtask

	task automatic irq_is(input logic p);
		chk(irq_vector, p ? `E1NB_VECTOR : `E1NB_VECTOR_IDLE);
		chk({7'h00, irq_n}, {7'h00, !p});
	endtask

	task automatic prbs_hit();
		@(posedge clk);
		prbs_err_pulse <= 1'b1;
		@(posedge clk);
		prbs_err_pulse <= 1'b0;
		@(negedge clk);
	endtask

	task automatic sa(input logic [3:0] b);
		@(posedge clk);
		sa_bits <= b;
		sa_bit_valid <= 1'b1;
		@(posedge clk);
		sa_bit_valid <= 1'b0;
		@(negedge clk);
	endtask

	task automatic nib(input logic [15:0] v);
		@(posedge clk);
		sa_nibbles <= v;
		sa_nib_valid <= 1'b1;
		@(posedge clk);
		sa_nib_valid <= 1'b0;
		@(negedge clk);
	endtask

	task automatic slot(input logic [7:0] b);
		@(posedge clk);
		sig_slot_byte <= b;
		sig_slot_valid <= 1'b1;
		@(posedge clk);
		sig_slot_valid <= 1'b0;
		settle();
	endtask

	task automatic period(input logic rx, output int t);
		logic prev;
		logic cur;
		logic [2:0] hist;
		int k;
		t = 0;
		k = 0;
		hist = 3'h0;
		prev = 1'b1;
		repeat (2000) begin
			@(negedge clk);
			cur = rx ? rx_ccs_clk_out : ccs_tx_clk;
			hist = {hist[1:0], serial_sig_in};
			if (!rx && k == 1 && cur === 1'b1 && prev === 1'b0)
				chk({7'h00, serial_sig_out}, {7'h00, hist[2]});
			if (k == 1 && (rx ? rx_line_clk_en : bp_clk_en) === 1'b1)
				t++;
			if (cur === 1'b1 && prev === 1'b0)
				k++;
			prev = cur;
			if (k == 2)
				break;
		end
	endtask

	task automatic t_regs();
		chk({7'h00, irq_oe}, 8'h01);
		rd(`E1NB_ADDR_MASK, `E1NB_MASK_RST, 1'b1);
		rd(`E1NB_ADDR_CTRL, `E1NB_CTRL_RST, 1'b1);
		wr(`E1NB_ADDR_MASK, 8'hFF);
		rd(`E1NB_ADDR_MASK, `E1NB_MASK_USED, 1'b1);
		wr(`E1NB_ADDR_CTRL, 8'h1E);
		rd(`E1NB_ADDR_CTRL, 8'h1E, 1'b1);
		rd(5'h1B, 8'h00, 1'b0);
		wr(`E1NB_ADDR_CTRL, 8'h00);
	endtask

	task automatic t_prbs();
		wr(`E1NB_ADDR_MASK, 8'h20);
		prbs_hit();
		irq_is(1'b1);
		ack();
		irq_is(1'b0);
		wr(`E1NB_ADDR_MASK, 8'h00);
		prbs_hit();
		irq_is(1'b0);
		wr(`E1NB_ADDR_MASK, 8'h40);
		@(posedge clk);
		prbs_err_cnt <= `E1NB_PRBS_MAX;
		@(posedge clk);
		prbs_err_cnt <= `E1NB_PRBS_ZERO;
		@(posedge clk);
		@(negedge clk);
		irq_is(1'b1);
		ack();
		irq_is(1'b0);
		wr(`E1NB_ADDR_MASK, 8'h20);
		ctl(8'h40);
		chk({7'h00, irq_oe}, 8'h00);
		prbs_hit();
		ctl(8'h00);
		chk({7'h00, irq_oe}, 8'h01);
		irq_is(1'b0);
	endtask

	task automatic t_sa();
		wr(`E1NB_ADDR_MASK, 8'h01);
		sa(4'h0);
		sa(4'h8);
		irq_is(1'b0);
		sa(4'h9);
		irq_is(1'b1);
		ack();
		wr(`E1NB_ADDR_MASK, 8'h08);
		sa(4'h1);
		irq_is(1'b1);
		ack();
		wr(`E1NB_ADDR_MASK, 8'h02);
		nib(16'h0000);
		nib(16'h0001);
		irq_is(1'b0);
		nib(16'h0051);
		irq_is(1'b1);
		ack();
		wr(`E1NB_ADDR_MASK, 8'h10);
		nib(16'h1051);
		irq_is(1'b1);
		ack();
		wr(`E1NB_ADDR_MASK, 8'h04);
		for (int i = 1; i <= 8; i++) begin
			nib(16'h10A1);
			irq_is(i == 8);
		end
		ack();
	endtask

	task automatic t_serial();
		chk({6'h00, serial_data_oe, serial_sig_oe}, 8'h00);
		@(posedge clk) {tx_data_bit, tx_sig_bit} <= 2'h3;
		ctl(8'h80);
		chk({6'h00, serial_data_oe, serial_sig_oe}, 8'h03);
		chk({6'h00, serial_data_out, serial_sig_out}, 8'h03);
		@(posedge clk) data_out_alarm_tristate <= 1'b1;
		sig_out_alarm_tristate <= 1'b1;
		settle();
		chk({6'h00, serial_data_oe, serial_sig_oe}, 8'h03);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) {rx_ais, rx_locrc, rx_lofs, rx_los} <= 4'h1 << i;
			settle();
			chk({6'h00, serial_data_oe, serial_sig_oe}, 8'h01);
		end
		@(posedge clk) {rx_ais, rx_locrc, rx_lofs, rx_los} <= 4'h0;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) {rx_ais16, rx_lomf} <= 2'h1 << i;
			settle();
			chk({6'h00, serial_data_oe, serial_sig_oe}, 8'h02);
		end
		@(posedge clk) {rx_ais16, rx_lomf} <= 2'h0;
		ctl(8'h00);
		chk({6'h00, serial_data_oe, serial_sig_oe}, 8'h00);
	endtask

	task automatic t_sig();
		ctl(8'h10);
		chk({7'h00, tx_common_chan_sig}, 8'h01);
		ctl(8'h04);
		chk({6'h00, tx_common_chan_sig, counters_clear}, 8'h01);
		@(posedge clk) reg_cas_nibble <= 4'hC;
		ctl(8'h08);
		chk({4'h0, tx_cas_nibble}, 8'h0C);
		ctl(8'h00);
		slot(8'h3A);
		chk({rx_cas_nibble, tx_cas_nibble}, 8'hAA);
		ctl(8'h02);
		slot(8'h5A);
		chk({4'h0, rx_cas_nibble}, 8'h05);
		ctl(8'h01);
		period(1'b0, n);
		chk(n[7:0], 8'(4 * `E1NB_TX_CHAN_TICKS));
		period(1'b1, n);
		chk(n[7:0], 8'(4 * `E1NB_RX_CHAN_TICKS));
		ctl(8'h00);
		chk({6'h00, ccs_tx_clk, rx_ccs_clk_out}, 8'h00);
	endtask

	initial begin
		num_errors = 0;
		num_checks = 0;
		cycles = 0;
		ctrl_sh = 8'h00;
		rst = 1'b1;
		{cs_n, rd_n, wr_n} = 3'h7;
		page = `E1NB_PAGE;
		{addr, wdata, prbs_err_cnt, sig_slot_byte} = 29'h0;
		{prbs_err_pulse, sa_bit_valid, sa_nib_valid, sig_slot_valid} = 4'h0;
		{sa_bits, reg_cas_nibble, sa_nibbles} = 24'h0;
		{tx_data_bit, tx_sig_bit, data_out_alarm_tristate, sig_out_alarm_tristate} = 4'h0;
		{rx_los, rx_lofs, rx_locrc, rx_ais, rx_lomf, rx_ais16} = 6'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		settle();
		t_regs();
		t_prbs();
		t_sa();
		t_serial();
		t_sig();
		final_report();
	end
endmodule
`default_nettype wire
